// ---- core/ccdlt_pkg.sv ----
////////////////////////////////////////////////////////////////////////////
// Purpose: shared constants for the ccd line timing and threshold readout
// Assumes: one 20 MHz system clock, all pixel rates derived by enables
// Notes: times are kept in ns and turned into cycle counts here
////////////////////////////////////////////////////////////////////////////
package ccdlt_pkg;

  // system clock
  localparam int CLK_PERIOD_NS = 50;

  // least reset interruption inside each data pulse
  localparam int RST_MIN_NS = 50;
  // least time rounds up, never below one cycle
  localparam int RST_CYC_RAW = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CYC = (RST_CYC_RAW < 1) ? 1 : RST_CYC_RAW;

  // default system cycles per data pulse (2.5 MHz pixel rate)
  localparam int PIX_DIV_DEF = 8;
  // default strobe delay in cycles; strobe and data clock come STB_DLY+1 cycles after reset fall
  localparam int STB_DLY_DEF = 2;

  // exposure chain reload values
  localparam int EXP1_LOAD = 11;
  localparam int EXP2_LOAD = 14;

  // black reference strobe window, in data pulses
  localparam int BLK_PIX = 4;

  // readout group after the window, and the valid part of it
  localparam int READ_PIX = 14;
  localparam int VALID_PIX = 7;

  // common width for the small counters
  localparam int CW = 8;

  // reset value of the transport line while held by the preset
  localparam logic TP_HOLD_LVL = 1'b1;

endpackage

// ---- core/ccdlt_pulse_gen.sv ----
////////////////////////////////////////////////////////////////////////////
// Purpose: delayed one-shot, stands in for a monostable plus gate delay
// Assumes: trig is a one-cycle pulse, not repeated while a pulse runs
// Notes: pulse rises DELAY+1 cycles after trig and lasts WIDTH cycles
////////////////////////////////////////////////////////////////////////////
module ccdlt_pulse_gen
  import ccdlt_pkg::*;
#(
  parameter int DELAY = 0,
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic trig,
  output logic pulse
);

  if (WIDTH < 1 || WIDTH > 255 || DELAY < 0 || DELAY > 255) begin : g_chk
    $error("ccdlt_pulse_gen: DELAY or WIDTH out of range");
  end

  localparam logic [CW-1:0] DLY_L = CW'(DELAY);
  localparam logic [CW-1:0] WID_L = CW'(WIDTH - 1);

  typedef struct packed {
    logic waiting;
    logic [CW-1:0] dly;
    logic out;
    logic [CW-1:0] wid;
  } ccdlt_pg_t;

  ccdlt_pg_t s;
  ccdlt_pg_t next_s;

  // width stage first, then delay stage; a retrigger restarts the delay
  always_comb begin
    next_s = s;
    if (s.out) begin
      if (s.wid == '0) begin
        next_s.out = 1'b0;
      end else begin
        next_s.wid = s.wid - 1'b1;
      end
    end
    if (s.waiting) begin
      if (s.dly <= 1) begin
        next_s.waiting = 1'b0;
        next_s.out = 1'b1;
        next_s.wid = WID_L;
      end else begin
        next_s.dly = s.dly - 1'b1;
      end
    end
    if (trig) begin
      if (DLY_L == '0) begin
        next_s.out = 1'b1;
        next_s.wid = WID_L;
      end else begin
        next_s.waiting = 1'b1;
        next_s.dly = DLY_L;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pulse = s.out;

endmodule

// ---- core/ccdlt_readout.sv ----
////////////////////////////////////////////////////////////////////////////
// Purpose: line timing generator and one-bit threshold sampler for a
//   linear ccd: reset clock, transport clock, transfer pulse, black
//   reference strobes and the sampled video bit
// Assumes: comparator result arrives synchronous to clk, high = lighter
// Notes: one data pulse per PIX_DIV system cycles
//
// Notes on behaviour
// - one data pulse per master clock cycle
// - transport clock is master clock divided by two
// - reset pulse at least 50 ns per pulse
// - transport held by preset, released on borrow; here set on the second counter borrow, released at the first reset clock fall after the transfer pulse ends
// - first counter loads eleven, borrows after eleventh
// - black strobes start on twelfth data pulse
// - borrow toggles latch, opens strobe window
// - second counter counts borrows, reloads fourteen
// - only seven of fourteen following pulses valid
// - strobe and data clock delayed, opposite phase
// - flip-flop samples comparator once per pulse
// - output zero darker, one lighter than threshold
// - strobe only during the four black pulses
// - reset falling edge aligned with transport edge
////////////////////////////////////////////////////////////////////////////
module ccdlt_readout
  import ccdlt_pkg::*;
#(
  parameter int PIX_DIV = PIX_DIV_DEF,
  parameter int STB_DLY = STB_DLY_DEF,
  parameter int EXP1 = EXP1_LOAD,
  parameter int EXP2 = EXP2_LOAD,
  parameter int BLK = BLK_PIX
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic restart,
  input wire logic cmpIn,
  output logic rstClk,
  output logic transport,
  output logic xferClk,
  output logic strobe,
  output logic sampleClk,
  output logic dataOut,
  output logic dataValid
);

  ////////////////////////////////////////////////////////////////////////
  // elaboration checks

  // strobe and its registered copy must land inside the same data pulse
  if (PIX_DIV < 3 || PIX_DIV > 255 ||
      RST_CYC + STB_DLY + 2 >= PIX_DIV) begin : g_chk_pix
    $error("ccdlt_readout: PIX_DIV too small for reset and strobe delay");
  end
  if (EXP1 < BLK + 1 || EXP1 > 255 || EXP2 < 2 || EXP2 > 255 ||
      BLK < 1) begin : g_chk_cnt
    $error("ccdlt_readout: exposure counts out of range");
  end

  localparam logic [CW-1:0] PH_LAST = CW'(PIX_DIV - 1);
  localparam logic [CW-1:0] PH_RFALL = CW'(RST_CYC);
  localparam logic [CW-1:0] E1_L = CW'(EXP1);
  localparam logic [CW-1:0] E2_L = CW'(EXP2);
  localparam logic [CW-1:0] BLK_L = CW'(BLK);
  localparam logic [CW-1:0] RD_L = CW'(READ_PIX);
  localparam logic [CW-1:0] RD_VALID_ABOVE = CW'(READ_PIX - VALID_PIX);

  ////////////////////////////////////////////////////////////////////////
  // state

  typedef enum logic [1:0] {
    ST_EXPOSE,
    ST_XFER
  } ccdlt_line_t;

  typedef struct packed {
    ccdlt_line_t line;
    logic [CW-1:0] ph;
    logic [CW-1:0] cnt1;
    logic [CW-1:0] cnt2;
    logic winLatch;
    logic [CW-1:0] winCnt;
    logic [CW-1:0] readIdx;
    logic tpDiv;
    logic tpHold;
    logic transport;
    logic xferClk;
    logic strobe;
    logic sampleClk;
    logic dataOut;
    logic dataValid;
  } ccdlt_state_t;

  ccdlt_state_t s;
  ccdlt_state_t next_s;

  logic pixStart;
  logic pixEnd;
  logic rstFall;
  logic rstPulse;
  logic smpPulse;

  // phase counter is the divider enable: one data pulse per wrap
  assign pixStart = (s.ph == '0);
  assign pixEnd = (s.ph == PH_LAST);
  assign rstFall = (s.ph == PH_RFALL);

  ////////////////////////////////////////////////////////////////////////
  // one-shots standing in for the monostables and the gate delay chain

  // reset clock: rises the cycle after pixStart, RST_CYC cycles wide
  ccdlt_pulse_gen #(
    .DELAY(0),
    .WIDTH(RST_CYC)
  ) u_rst (
    .clk(clk),
    .resetn(resetn),
    .trig(pixStart),
    .pulse(rstPulse)
  );

  // strobe and data clock come off the low phase of the reset clock
  ccdlt_pulse_gen #(
    .DELAY(STB_DLY),
    .WIDTH(1)
  ) u_smp (
    .clk(clk),
    .resetn(resetn),
    .trig(rstFall),
    .pulse(smpPulse)
  );

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_s = s;
    next_s.strobe = 1'b0;
    next_s.sampleClk = 1'b0;

    // pixel phase divider
    if (pixEnd) begin
      next_s.ph = '0;
    end else begin
      next_s.ph = s.ph + 1'b1;
    end

    // transport moves only on the reset clock falling edge or a restart, so that a
    // release after the preset never lands off that edge and rings
    if (rstFall) begin
      next_s.tpDiv = ~s.tpDiv;
      next_s.transport = s.tpHold ? TP_HOLD_LVL : ~s.tpDiv;
    end

    // sample point: well inside the valid video part of the pulse
    if (smpPulse) begin
      next_s.sampleClk = 1'b1;
      next_s.dataOut = cmpIn;
      next_s.strobe = s.winLatch;
      next_s.dataValid = (s.readIdx > RD_VALID_ABOVE);
    end

    // pixel bookkeeping at the end of each data pulse
    if (pixEnd) begin
      if (s.readIdx != '0) begin
        next_s.readIdx = s.readIdx - 1'b1;
      end
      // strobe window counts its pulses, then the latch falls back
      if (s.winLatch) begin
        if (s.winCnt <= 1) begin
          next_s.winLatch = 1'b0;
          next_s.winCnt = '0;
          next_s.readIdx = RD_L;
        end else begin
          next_s.winCnt = s.winCnt - 1'b1;
        end
      end

      // transfer pulse and transport preset last exactly one pulse
      next_s.xferClk = 1'b0;
      next_s.tpHold = 1'b0;
      next_s.line = ST_EXPOSE;

      // first counter: borrow at the end of the EXP1th pulse
      if (s.cnt1 <= 1) begin
        next_s.cnt1 = E1_L;
        // first borrow of the line opens the black reference window
        if (s.cnt2 == E2_L) begin
          next_s.winLatch = 1'b1;
          next_s.winCnt = BLK_L;
        end
        // second counter counts borrows; its borrow starts a transfer
        if (s.cnt2 <= 1) begin
          next_s.cnt2 = E2_L;
          next_s.xferClk = 1'b1;
          next_s.tpHold = 1'b1;
          next_s.line = ST_XFER;
        end else begin
          next_s.cnt2 = s.cnt2 - 1'b1;
        end
      end else begin
        next_s.cnt1 = s.cnt1 - 1'b1;
      end
    end

    // hold the preset on the transport line during the transfer pulse
    case (s.line)
      ST_XFER: begin
        if (rstFall) begin
          next_s.transport = TP_HOLD_LVL;
        end
      end
      ST_EXPOSE: begin
        next_s.transport = next_s.transport;
      end
      default: begin
        next_s.line = ST_EXPOSE;
      end
    endcase

    // software-free restart; phase keeps running so pulses stay whole
    if (restart) begin
      next_s.cnt1 = E1_L;
      next_s.cnt2 = E2_L;
      next_s.winLatch = 1'b0;
      next_s.winCnt = '0;
      next_s.readIdx = '0;
      next_s.tpHold = 1'b1;
      next_s.transport = TP_HOLD_LVL;
      next_s.xferClk = 1'b0;
      next_s.line = ST_EXPOSE;
      next_s.strobe = 1'b0;
      next_s.dataValid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  // async reset leaves the chain loaded and the transport preset held
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s <= '{
        line: ST_EXPOSE,
        ph: '0,
        cnt1: E1_L,
        cnt2: E2_L,
        winLatch: 1'b0,
        winCnt: '0,
        readIdx: '0,
        tpDiv: 1'b0,
        tpHold: 1'b1,
        transport: TP_HOLD_LVL,
        xferClk: 1'b0,
        strobe: 1'b0,
        sampleClk: 1'b0,
        dataOut: 1'b0,
        dataValid: 1'b0
      };
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, each straight from a flop

  assign rstClk = rstPulse;
  assign transport = s.transport;
  assign xferClk = s.xferClk;
  assign strobe = s.strobe;
  assign sampleClk = s.sampleClk;
  assign dataOut = s.dataOut;
  assign dataValid = s.dataValid;

endmodule

// ---- testbench/ccdlt_readout_properties.sv ----
////////////////////////////////////////
// Purpose: timing checks on the readout ports
// Assumes: default divider of 8, reset width 1
// Notes: line counts gated until a full line is seen
////////////////////////////////////////
module ccdlt_props
  import ccdlt_pkg::*;
#(
  parameter int PIX_DIV = PIX_DIV_DEF,
  parameter int STB_DLY = STB_DLY_DEF,
  parameter int BLK = BLK_PIX
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic restart,
  input wire logic cmpIn,
  input wire logic rstClk,
  input wire logic transport,
  input wire logic xferClk,
  input wire logic strobe,
  input wire logic sampleClk,
  input wire logic dataOut,
  input wire logic dataValid
);
  localparam int SDLY = STB_DLY + 1;
  logic seen;
  logic [CW-1:0] pcnt;
  logic [CW-1:0] scnt;
  logic [CW-1:0] vcnt;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // tallies since the last transfer; restart voids the line length
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      seen <= 1'b0;
      pcnt <= '0;
      scnt <= '0;
      vcnt <= '0;
    end else begin
      seen <= restart ? 1'b0 : (seen | $rose(xferClk));
      if ($rose(xferClk)) begin
        pcnt <= CW'($rose(rstClk));
        scnt <= '0;
      end else begin
        pcnt <= pcnt + CW'($rose(rstClk));
        scnt <= scnt + CW'($rose(strobe));
      end
      if ($rose(sampleClk)) begin
        vcnt <= dataValid ? vcnt + CW'(1) : '0;
      end
    end
  end
  a_rst_width: assert property ($rose(rstClk) |=> !rstClk)
    else $error("reset clock pulse too long");
  a_pix_period: assert property ($rose(rstClk) |-> ##PIX_DIV $rose(rstClk))
    else $error("data pulse period wrong");
  a_tp_align: assert property ($changed(transport) |->
    $fell(rstClk) || $fell(xferClk) || $past(restart))
    else $error("transport moved off reset fall");
  a_xfer_width: assert property ($rose(xferClk) |-> xferClk[*8] ##1 !xferClk)
    else $error("transfer pulse width wrong");
  a_line_len: assert property ($rose(xferClk) && seen |-> pcnt == 8'd154)
    else $error("line length not 154 pulses");
  a_strobe_place: assert property (strobe && seen |->
    sampleClk && pcnt >= 8'd12 && pcnt <= 8'd15)
    else $error("strobe outside black pulses");
  a_strobe_count: assert property ($rose(xferClk) && seen |-> scnt == BLK)
    else $error("wrong strobe count per line");
  a_samp_delay: assert property ($fell(rstClk) |-> ##SDLY $rose(sampleClk))
    else $error("sample clock misplaced");
  a_data_capt: assert property ($rose(sampleClk) |-> dataOut == $past(cmpIn))
    else $error("sampled bit differs from comparator");
  a_data_hold: assert property ($changed(dataOut) |-> $rose(sampleClk))
    else $error("data bit changed between samples");
  a_valid_run: assert property ($fell(dataValid) && !$past(restart) |->
    vcnt == VALID_PIX)
    else $error("valid run not seven pulses");
endmodule

bind ccdlt_readout ccdlt_props #(
  .PIX_DIV(PIX_DIV),
  .STB_DLY(STB_DLY),
  .BLK(BLK)
) u_ccdlt_props (
  .clk(clk),
  .resetn(resetn),
  .restart(restart),
  .cmpIn(cmpIn),
  .rstClk(rstClk),
  .transport(transport),
  .xferClk(xferClk),
  .strobe(strobe),
  .sampleClk(sampleClk),
  .dataOut(dataOut),
  .dataValid(dataValid)
);

// ---- testbench/ccdlt_sensor_model.sv ----
////////////////////////////////////////
// Purpose: sensor plus comparator seen from the block
// Assumes: pixel index restarts on the transfer pulse
// Notes: fixed light pattern, black pulses read dark
////////////////////////////////////////
module ccdlt_sensor_model
  import ccdlt_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic rstClk,
  input wire logic xferClk,
  output logic cmpIn
);
  logic rq;
  logic [CW-1:0] pix;
  // pixel index per reset clock, 1 on the transfer pulse
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rq <= 1'b0;
      pix <= '0;
    end else begin
      rq <= rstClk;
      if (rstClk && !rq) begin
        pix <= xferClk ? CW'(1) : pix + CW'(1);
      end
    end
  end
  // black reference pulses 12..15 read darker than threshold
  assign cmpIn = (pix >= 12 && pix <= 15) ? 1'b0 : pix[0] ^ pix[2];
endmodule

// ---- testbench/test_ccdlt_readout.sv ----
////////////////////////////////////////
// Purpose: directed tests of the line timing readout
// Assumes: default parameters, 50 ns clock
// Notes: outputs sampled 1 ns after the rising edge
////////////////////////////////////////
module test_ccdlt_readout;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
    err_total++; $display("CHECK FAILED %s exp %0d got %0d", n, e, g); end end
  logic clk, resetn, restart, cmpIn, rstClk, transport;
  logic xferClk, strobe, sampleClk, dataOut, dataValid;
  int err_total, checked;
  ccdlt_readout u_ccdlt_readout (.clk(clk), .resetn(resetn),
    .restart(restart), .cmpIn(cmpIn), .rstClk(rstClk),
    .transport(transport), .xferClk(xferClk), .strobe(strobe),
    .sampleClk(sampleClk), .dataOut(dataOut), .dataValid(dataValid));
  ccdlt_sensor_model u_ccdlt_sensor_model (.clk(clk), .resetn(resetn),
    .rstClk(rstClk), .xferClk(xferClk), .cmpIn(cmpIn));
  initial clk = 1'b0;
  always #25 clk = ~clk;
  ////////////////////////////////////////
  // single exit for pass, fail and hangs
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic hang;
    err_total++;
    $display("CHECK FAILED wait exp done got timeout");
    print_verdict();
  endtask
  // next sample point; a stuck sample clock ends the run
  task automatic wsamp;
    int n;
    n = 0;
    do begin tick(); n++; end while (sampleClk !== 1'b1 && n < 20);
    if (n >= 20) hang();
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    @(posedge clk);
    resetn <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    `CHK("rst rstClk", 1'b0, rstClk)
    `CHK("rst transport", 1'b1, transport)
    `CHK("rst xfer", 1'b0, xferClk)
    `CHK("rst valid", 1'b0, dataValid)
    @(posedge clk);
    resetn <= 1'b1;
    $display("reset test done");
  endtask
  task automatic t_pulse;
    int n;
    n = 0;
    do begin tick(); n++; end while (rstClk !== 1'b1 && n < 20);
    tick();
    `CHK("rst width", 1'b0, rstClk)
    n = 0;
    do begin tick(); n++; end while (rstClk !== 1'b1 && n < 20);
    `CHK("pulse period", 7, n)
    $display("pulse test done");
  endtask
  // one whole line walked pulse by pulse from the transfer
  task automatic t_line;
    int i, n;
    logic tp, ex;
    n = 0;
    do begin wsamp(); n++; end while (xferClk !== 1'b1 && n < 200);
    if (n >= 200) hang();
    for (i = 1; i <= 154; i++) begin
      ex = (i >= 12 && i <= 15) ? 1'b0 : i[0] ^ i[2];
      `CHK("xfer", i == 1, xferClk)
      `CHK("strobe", i >= 12 && i <= 15, strobe)
      `CHK("valid", i >= 16 && i <= 22, dataValid)
      `CHK("data", ex, dataOut)
      if (i == 1) `CHK("tp hold", 1'b1, transport)
      if (i >= 3) `CHK("tp toggle", ~tp, transport)
      tp = transport;
      wsamp();
    end
    `CHK("next xfer", 1'b1, xferClk)
    $display("line test done");
  endtask
  // restart in mid valid run must drop valid and hold transport
  task automatic t_restart;
    int n;
    n = 0;
    do begin tick(); n++; end while (dataValid !== 1'b1 && n < 3000);
    if (n >= 3000) hang();
    @(posedge clk);
    restart <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
    #1;
    `CHK("restart tp", 1'b1, transport)
    `CHK("restart valid", 1'b0, dataValid)
    $display("restart test done");
  endtask
  ////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    restart = 1'b0;
    err_total = 0;
    checked = 0;
    t_reset();
    t_pulse();
    t_line();
    t_line();
    t_restart();
    t_line();
    t_reset();
    t_line();
    print_verdict();
  end
endmodule
